/* File: hw/fps_host.sv */
// Host sequencer: enter, exit, protect-verify and plain writes to the flash pins
// *****************************************
// What this block does
// *****************************************
// What this block does
// - Host verifies after enter sequence, protect-verify algorithm; the verify request does not check the region and runs outside it too
// - Verify: write 60h, 40h, wait 1 ms, read
// - Host exits region before array access; the write request neither checks the region nor exits it
// - Write needs chip and write low, output high
`include "fps_regs.svh"
module fps_host
    import fps_pkg::*;
#(
    parameter int VERIFY_WAIT = `FPS_VERIFY_WAIT_CYC,
    parameter int STROBE = `FPS_STROBE_CYC
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic reqValid,
    input wire fps_op_e reqOp,
    input wire logic [21:0] reqAddr,
    input wire logic [7:0] reqData,
    input wire logic [7:0] dqIn,
    output logic reqBusy,
    output logic doneValid,
    output logic verifyProtected,
    output logic [7:0] verifyData,
    output fps_bus_s flashBus,
    output logic guardInputN,
    output logic regionActive
);

    typedef struct packed {
        fps_st_e st;
        fps_op_e op;
        logic [2:0] step;
        logic [2:0] last;
        logic [31:0] cnt;
        logic [21:0] userAddr;
        logic [7:0] userData;
        fps_bus_s bus;
        logic busy;
        logic done;
        logic prot;
        logic [7:0] vdata;
        logic region;
        logic guardN;
    } fps_state_s;

    fps_state_s state_q;
    fps_state_s state_d;

    // *****************************************
    // Cycle table: address and data for each step of an operation
    // *****************************************
    function automatic logic [29:0] cycleOf(input fps_op_e op, input logic [2:0] step,
                                            input logic [21:0] ua, input logic [7:0] ud);
        logic [29:0] r;
        r = {ua, ud};
        case (op)
            FPS_OP_ENTER:
            begin
                case (step)
                    3'h0: r = {`FPS_ADDR_UNLOCK1, `FPS_CMD_EXIT_A};
                    3'h1: r = {`FPS_ADDR_UNLOCK2, `FPS_CMD_EXIT_B};
                    default: r = {`FPS_ADDR_UNLOCK1, `FPS_CMD_ENTER_C};
                endcase
            end
            FPS_OP_EXIT:
            begin
                case (step)
                    3'h0: r = {`FPS_ADDR_UNLOCK1, `FPS_CMD_EXIT_A};
                    3'h1: r = {`FPS_ADDR_UNLOCK2, `FPS_CMD_EXIT_B};
                    3'h2: r = {`FPS_ADDR_UNLOCK1, `FPS_CMD_EXIT_C};
                    default: r = {22'h000000, `FPS_CMD_EXIT_D};
                endcase
            end
            FPS_OP_VERIFY:
            begin
                case (step)
                    3'h0: r = {ua, `FPS_CMD_VERIFY_SETUP};
                    default: r = {`FPS_ADDR_VERIFY, `FPS_CMD_VERIFY_READ};
                endcase
            end
            default: r = {ua, ud};
        endcase
        return r;
    endfunction

    // *****************************************
    // Sequencer
    // *****************************************
    always_comb
    begin
        logic [29:0] cyc;
        cyc = cycleOf(state_q.op, state_q.step, state_q.userAddr, state_q.userData);
        state_d = state_q;
        state_d.done = 1'b0;
        case (state_q.st)
            FPS_IDLE:
            begin
                state_d.busy = 1'b0;
                if (reqValid)
                begin
                    state_d.op = reqOp;
                    state_d.userAddr = reqAddr;
                    state_d.userData = reqData;
                    state_d.step = 3'h0;
                    state_d.busy = 1'b1;
                    case (reqOp)
                        FPS_OP_ENTER: state_d.last = 3'h2;
                        FPS_OP_EXIT: state_d.last = 3'h3;
                        FPS_OP_VERIFY: state_d.last = 3'h1;
                        default: state_d.last = 3'h0;
                    endcase
                    state_d.st = FPS_CYC_SET;
                end
            end
            FPS_CYC_SET:
            begin
                // Address and data settle with strobes high before the write starts
                state_d.bus.addr = cyc[29:8];
                state_d.bus.dq = cyc[7:0];
                state_d.bus.dqOe = 1'b1;
                state_d.bus.oeN = 1'b1;
                state_d.cnt = 32'(STROBE);
                state_d.st = FPS_CYC_LOW;
            end
            FPS_CYC_LOW:
            begin
                // Strobe held for whole cycles, far longer than a glitch
                state_d.bus.ceN = 1'b0;
                state_d.bus.weN = 1'b0;
                state_d.cnt = state_q.cnt - 32'h1;
                if (state_q.cnt == 32'h1)
                begin
                    state_d.st = FPS_CYC_HIGH;
                end
            end
            FPS_CYC_HIGH:
            begin
                state_d.bus.weN = 1'b1;
                state_d.bus.ceN = 1'b1;
                state_d.st = FPS_NEXT;
            end
            FPS_NEXT:
            begin
                state_d.bus.dqOe = 1'b0;
                if (state_q.step == state_q.last)
                begin
                    if (state_q.op == FPS_OP_VERIFY)
                    begin
                        state_d.cnt = 32'(VERIFY_WAIT);
                        state_d.st = FPS_WAIT;
                    end
                    else
                    begin
                        if (state_q.op == FPS_OP_ENTER)
                            state_d.region = 1'b1;
                        if (state_q.op == FPS_OP_EXIT)
                            state_d.region = 1'b0;
                        state_d.done = 1'b1;
                        state_d.busy = 1'b0;
                        state_d.st = FPS_IDLE;
                    end
                end
                else
                begin
                    state_d.step = state_q.step + 3'h1;
                    state_d.st = FPS_CYC_SET;
                end
            end
            FPS_WAIT:
            begin
                state_d.cnt = state_q.cnt - 32'h1;
                if (state_q.cnt <= 32'h1)
                begin
                    state_d.cnt = 32'(STROBE);
                    state_d.st = FPS_READ_LOW;
                end
            end
            FPS_READ_LOW:
            begin
                state_d.bus.ceN = 1'b0;
                state_d.bus.oeN = 1'b0;
                state_d.cnt = state_q.cnt - 32'h1;
                if (state_q.cnt == 32'h1)
                begin
                    state_d.vdata = dqIn;
                    state_d.prot = (dqIn == `FPS_VERIFY_PROT);
                    state_d.st = FPS_READ_DONE;
                end
            end
            FPS_READ_DONE:
            begin
                state_d.bus.ceN = 1'b1;
                state_d.bus.oeN = 1'b1;
                state_d.done = 1'b1;
                state_d.busy = 1'b0;
                state_d.st = FPS_IDLE;
            end
            default: state_d.st = FPS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            state_q <= '0;
            state_q.st <= FPS_IDLE;
            state_q.bus.ceN <= 1'b1;
            state_q.bus.weN <= 1'b1;
            state_q.bus.oeN <= 1'b1;
            state_q.guardN <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign reqBusy = state_q.busy;
    assign doneValid = state_q.done;
    assign verifyProtected = state_q.prot;
    assign verifyData = state_q.vdata;
    assign flashBus = state_q.bus;
    assign regionActive = state_q.region;
    // Guard pin held high so boot sectors follow their stored protection
    assign guardInputN = state_q.guardN;
endmodule

/* File: hw/fps_pkg.sv */
// Types shared by the flash protection host controller
package fps_pkg;
    typedef enum logic [1:0] {
        FPS_OP_ENTER,
        FPS_OP_EXIT,
        FPS_OP_VERIFY,
        FPS_OP_WRITE
    } fps_op_e;

    typedef struct packed {
        logic ceN;
        logic weN;
        logic oeN;
        logic [21:0] addr;
        logic [7:0] dq;
        logic dqOe;
    } fps_bus_s;

    typedef enum logic [3:0] {
        FPS_IDLE,
        FPS_CYC_SET,
        FPS_CYC_LOW,
        FPS_CYC_HIGH,
        FPS_WAIT,
        FPS_READ_LOW,
        FPS_READ_DONE,
        FPS_NEXT
    } fps_st_e;
endpackage

/* File: hw/fps_regs.svh */
// Timing counts and command codes for the flash protection host controller
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH
`define FPS_CLK_MHZ 25
`define FPS_VERIFY_WAIT_US 1000
`define FPS_VERIFY_WAIT_CYC (`FPS_VERIFY_WAIT_US * `FPS_CLK_MHZ)
`define FPS_GLITCH_NS 5
`define FPS_STROBE_CYC 2
`define FPS_CMD_VERIFY_SETUP 8'h60
`define FPS_CMD_VERIFY_READ 8'h40
`define FPS_CMD_EXIT_A 8'haa
`define FPS_CMD_EXIT_B 8'h55
`define FPS_CMD_EXIT_C 8'h90
`define FPS_CMD_EXIT_D 8'h00
`define FPS_CMD_ENTER_C 8'h88
`define FPS_ADDR_UNLOCK1 22'h000555
`define FPS_ADDR_UNLOCK2 22'h0002aa
`define FPS_ADDR_VERIFY 22'h000002
`define FPS_IND_FACTORY 8'h81
`define FPS_IND_CUSTOMER 8'h41
`define FPS_IND_OPEN 8'h01
`define FPS_VERIFY_PROT 8'h01
`define FPS_VERIFY_UNPROT 8'h00
`endif

/* File: tb/fps_flash_model.sv */
// Behavioural flash device answering the host's command cycles
module fps_flash_model
    import fps_pkg::*;
#(
    parameter bit LOCKED = 1'b1
)
(
    input wire fps_bus_s flashBus,
    input wire logic guardInputN,
    output logic [7:0] dqIn,
    output logic [7:0] progData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] h1 = 8'h00;
    logic [7:0] h2 = 8'h00;
    logic regionOn = 1'b0;
    logic verifyOn = 1'b0;
    logic armed = 1'b0;
    logic powered = 1'b0;
    logic bootHit;
    logic [21:0] cAddr = 22'h0;
    logic [7:0] cDq = 8'h00;
    logic [7:0] lastProg = 8'h00;
    realtime tLow = 0.0;
    logic [7:0] rdVal;
    // A write is armed while chip and write enable are low and output enable is high;
    // it lands when the first of the two strobes rises, so both may rise together
    always @(flashBus)
    begin
        if (!flashBus.ceN && !flashBus.weN && flashBus.oeN)
        begin
            if (!armed)
                tLow = $realtime;
            armed = powered;
            cAddr = flashBus.addr;
            cDq = flashBus.dq;
        end
        else
        begin
            powered = 1'b1;
            if (armed && ($realtime - tLow) >= 5.0)
            begin
                if (cDq == 8'h88 && h1 == 8'h55 && h2 == 8'haa)
                    regionOn = 1'b1;
                if (cDq == 8'h00 && h1 == 8'h90)
                    regionOn = 1'b0;
                verifyOn = regionOn && cDq == 8'h40 && h1 == 8'h60
                    && !cAddr[6] && cAddr[1:0] == 2'b10;
                // Boot sectors refuse data while the guard is low; none is stored protected
                if (!(bootHit && !guardInputN))
                    lastProg = cDq;
                h2 = h1;
                h1 = cDq;
            end
            armed = 1'b0;
        end
    end
    assign bootHit = (cAddr[21:13] == 9'h000) || (cAddr[21:13] == 9'h1ff);
    assign progData = lastProg;
    // Lock is permanent, so the verify answer never changes
    assign rdVal = verifyOn ? {7'h00, LOCKED} : 8'hff;
    // Released bus shows the inverse so a stale value cannot pass
    assign dqIn = (!flashBus.ceN && !flashBus.oeN) ? rdVal : ~rdVal;
endmodule

/* File: tb/fps_host_assertions.sv */
// Checker for the flash host pin protocol
module fps_host_assertions
    import fps_pkg::*;
#(
    parameter int VERIFY_WAIT = 20
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire fps_bus_s flashBus,
    input wire logic doneValid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] gapQ;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Gap since the last write strobe, for the settle wait before a read
    always_ff @(posedge ref_clk)
    begin
        gapQ <= (!nrst || !flashBus.weN) ? 32'h0 : gapQ + 32'h1;
    end
    sequence s_write;
        !flashBus.ceN && !flashBus.weN;
    endsequence
    sequence s_read_start;
        $fell(flashBus.oeN) && !flashBus.ceN;
    endsequence
    a_write_oe_high: assert property (s_write |-> flashBus.oeN)
        else $error("write strobe with output enable low");
    a_write_drives_dq: assert property (s_write |-> flashBus.dqOe)
        else $error("write strobe without data driven");
    a_read_releases: assert property (!flashBus.oeN |-> flashBus.weN && !flashBus.dqOe)
        else $error("read strobe while writing or driving data");
    a_verify_wait_gap: assert property (s_read_start |-> gapQ >= VERIFY_WAIT)
        else $error("verify read too soon after command");
    a_read_then_done: assert property (s_read_start |-> ##[1:8] doneValid)
        else $error("verify read not completed");
endmodule

bind fps_host fps_host_assertions #(.VERIFY_WAIT(VERIFY_WAIT)) i_chk (
    .ref_clk(ref_clk), .nrst(nrst), .flashBus(flashBus), .doneValid(doneValid));

/* File: tb/fps_host_tb_top.sv */
// Self-checking bench for the flash protection host controller
module fps_host_tb_top
    import fps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int VW = 20;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic reqValid = 1'b0;
    fps_op_e reqOp = FPS_OP_WRITE;
    logic [21:0] reqAddr = 22'h0;
    logic [7:0] reqData = 8'h00;
    logic [7:0] dqIn, verifyData, wData, progData;
    logic reqBusy, doneValid, verifyProtected, guardInputN, regionActive;
    logic [21:0] wAddr;
    fps_bus_s flashBus;
    int n_fail = 0;
    int n_checks = 0;
    int cyc;
    fps_host #(.VERIFY_WAIT(VW), .STROBE(2)) i_dut (.ref_clk(ref_clk), .nrst(nrst),
        .reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr), .reqData(reqData),
        .dqIn(dqIn), .reqBusy(reqBusy), .doneValid(doneValid),
        .verifyProtected(verifyProtected), .verifyData(verifyData),
        .flashBus(flashBus), .guardInputN(guardInputN), .regionActive(regionActive));
    fps_flash_model i_flash (.flashBus(flashBus), .guardInputN(guardInputN), .dqIn(dqIn),
        .progData(progData));
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************************************
    // Request and completion
    // ****************************************
    task automatic run_op(input fps_op_e op, input logic [21:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reqValid <= 1'b1;
        reqOp <= op;
        reqAddr <= a;
        reqData <= d;
        @(posedge ref_clk);
        reqValid <= 1'b0;
        for (cyc = 1; cyc < 200; cyc++)
        begin
            @(posedge ref_clk);
            #1;
            if (cyc == 1)
                chk(reqBusy, 1'b1);
            if (!flashBus.weN)
            begin
                wAddr = flashBus.addr;
                wData = flashBus.dq;
            end
            if (doneValid === 1'b1)
                break;
        end
        if (cyc == 200)
        begin
            n_fail++;
            $display("Error %0t: no completion", $time);
            final_report();
        end
        chk(reqBusy, 1'b0);
    endtask
    task automatic t_idle();
        chk({flashBus.ceN, flashBus.weN, flashBus.oeN, flashBus.dqOe}, 4'he);
        chk({guardInputN, regionActive}, 2'b10);
    endtask
    task automatic t_verify_outside();
        run_op(FPS_OP_VERIFY, 22'h000010, 8'h00);
        chk({verifyProtected, verifyData}, 9'h0ff);
    endtask
    task automatic t_region_cycle();
        run_op(FPS_OP_ENTER, 22'h0, 8'h00);
        chk(regionActive, 1'b1);
        run_op(FPS_OP_VERIFY, 22'h000010, 8'h00);
        chk({verifyProtected, verifyData}, 9'h101);
        chk(cyc >= VW, 1'b1);
        run_op(FPS_OP_EXIT, 22'h0, 8'h00);
        chk(regionActive, 1'b0);
    endtask
    task automatic t_write();
        run_op(FPS_OP_WRITE, 22'h3f0010, 8'ha5);
        chk(wAddr, 22'h3f0010);
        chk(wData, 8'ha5);
        chk(progData, 8'ha5);
        t_idle();
    endtask
    initial
    begin
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        #1;
        t_idle();
        t_verify_outside();
        t_region_cycle();
        t_write();
        final_report();
    end
endmodule
